// *** amg_pkg.sv ***
// shared constants for the input mux and amplifier gain register bank
package amg_pkg;
    localparam int          AMG_ADDR_W       = 4;
    localparam int          AMG_DATA_W       = 32;
    localparam int          AMG_REG_W        = 8;
    // word offsets of the two registers
    localparam logic [3:0]  AMG_OFS_INSEL    = 4'h2;
    localparam logic [3:0]  AMG_OFS_GAIN     = 4'h3;
    // reset values
    localparam logic [7:0]  AMG_RST_INSEL    = 8'h01;
    localparam logic [7:0]  AMG_RST_GAIN     = 8'h00;
    // field positions
    localparam int          AMG_POS_MSB      = 7;
    localparam int          AMG_POS_LSB      = 4;
    localparam int          AMG_NEG_MSB      = 3;
    localparam int          AMG_NEG_LSB      = 0;
    localparam int          AMG_EN_MSB       = 4;
    localparam int          AMG_EN_LSB       = 3;
    localparam int          AMG_GN_MSB       = 2;
    localparam int          AMG_GN_LSB       = 0;
    // amplifier enable codes
    localparam logic [1:0]  AMG_EN_BYPASS    = 2'h0;
    localparam logic [1:0]  AMG_EN_ACTIVE    = 2'h1;
    // unmapped reads return this
    localparam logic [31:0] AMG_UNMAPPED     = 32'h0000_0000;
endpackage : amg_pkg

// *** amg_cfg_if.sv ***
// carrier between the register bank and the field decoder
`timescale 1ns/1ps
interface amg_cfg_if;
    logic [7:0] insel;
    logic [7:0] gain;
    logic [3:0] pos_sel;
    logic [3:0] neg_sel;
    logic       amp_on;
    logic       amp_rsvd;
    logic [7:0] gain_factor;
    modport bank (output insel, output gain, input pos_sel, input neg_sel,
                  input amp_on, input amp_rsvd, input gain_factor);
    modport dec  (input insel, input gain, output pos_sel, output neg_sel,
                  output amp_on, output amp_rsvd, output gain_factor);
endinterface : amg_cfg_if

// *** amg_field_dec.sv ***
// field decoder: input selects, amplifier mode and gain factor
`timescale 1ns/1ps
module amg_field_dec
    import amg_pkg::*;
(
    amg_cfg_if.dec cfg
);
    function automatic logic [7:0] amg_gain_of(input logic [2:0] code);
        amg_gain_of = 8'h01 << code;
    endfunction : amg_gain_of

    wire [1:0] en_code = cfg.gain[AMG_EN_MSB:AMG_EN_LSB];

    assign cfg.pos_sel     = cfg.insel[AMG_POS_MSB:AMG_POS_LSB];
    assign cfg.neg_sel     = cfg.insel[AMG_NEG_MSB:AMG_NEG_LSB];
    assign cfg.amp_on      = (en_code == AMG_EN_ACTIVE);
    assign cfg.amp_rsvd    = en_code[1];
    // bypass forces unity regardless of the stored gain code
    assign cfg.gain_factor = cfg.amp_on ?
                             amg_gain_of(cfg.gain[AMG_GN_MSB:AMG_GN_LSB]) : 8'h01;
endmodule : amg_field_dec

// *** amg_regs.sv ***
// input mux and amplifier gain configuration registers on avalon-mm
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/1ps
module amg_regs
    import amg_pkg::*;
(
    // clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  rst_n,
    // avalon-mm slave
    input  wire logic [AMG_ADDR_W-1:0] avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [AMG_DATA_W-1:0] avs_writedata,
    input  wire logic [3:0]            avs_byteenable,
    output logic      [AMG_DATA_W-1:0] avs_readdata,
    output logic                       avs_waitrequest,
    // configuration towards the converter
    output logic      [3:0]            positive_input_select,
    output logic      [3:0]            negative_input_select,
    output logic                       amplifier_enable,
    output logic                       amplifier_mode_reserved,
    output logic      [2:0]            amplifier_gain_code,
    output logic      [7:0]            amplifier_gain_factor
);
    amg_cfg_if cfg ();

    // field slices shared by the reset branches and the checks
    function automatic logic [3:0] amg_hi_nib(input logic [7:0] r);
        amg_hi_nib = r[AMG_POS_MSB:AMG_POS_LSB];
    endfunction : amg_hi_nib

    function automatic logic [3:0] amg_lo_nib(input logic [7:0] r);
        amg_lo_nib = r[AMG_NEG_MSB:AMG_NEG_LSB];
    endfunction : amg_lo_nib

    function automatic logic [2:0] amg_code_of(input logic [7:0] r);
        amg_code_of = r[AMG_GN_MSB:AMG_GN_LSB];
    endfunction : amg_code_of

    function automatic logic [1:0] amg_mode_of(input logic [7:0] r);
        amg_mode_of = r[AMG_EN_MSB:AMG_EN_LSB];
    endfunction : amg_mode_of

    logic [7:0]            input_channel_select_r;
    logic [7:0]            amplifier_gain_setting_r;
    logic                  ack_r;
    logic [AMG_DATA_W-1:0] rdata_nxt;

    amg_field_dec u_dec (
        .cfg (cfg)
    );

    assign cfg.insel = input_channel_select_r;
    assign cfg.gain  = amplifier_gain_setting_r;

    // one wait cycle: ack rises the cycle after the request, request then accepted
    wire req      = (avs_read | avs_write) & ~ack_r;
    wire hit_in   = (avs_address == AMG_OFS_INSEL);
    wire hit_gn   = (avs_address == AMG_OFS_GAIN);
    wire wr_take  = avs_write & ack_r & avs_byteenable[0];
    wire wr_in    = wr_take & hit_in;
    wire wr_gn    = wr_take & hit_gn;

    assign rdata_nxt = hit_in ? {24'h000000, input_channel_select_r} :
                       hit_gn ? {24'h000000, amplifier_gain_setting_r} : AMG_UNMAPPED;

    // waitrequest is its own flop so the bus output comes straight from a register
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ack_r           <= 1'b0;
            avs_waitrequest <= 1'b1;
        end else begin
            ack_r           <= req;
            avs_waitrequest <= ~req;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            input_channel_select_r   <= AMG_RST_INSEL;
            amplifier_gain_setting_r <= AMG_RST_GAIN;
        end else begin
            if (wr_in) begin
                input_channel_select_r <= avs_writedata[7:0];
            end
            if (wr_gn) begin
                amplifier_gain_setting_r <= avs_writedata[7:0];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            avs_readdata <= AMG_UNMAPPED;
        end else if (avs_read & ~ack_r) begin
            avs_readdata <= rdata_nxt;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            positive_input_select <= amg_hi_nib(AMG_RST_INSEL);
            negative_input_select <= amg_lo_nib(AMG_RST_INSEL);
        end else begin
            positive_input_select <= cfg.pos_sel;
            negative_input_select <= cfg.neg_sel;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            amplifier_enable        <= 1'b0;
            amplifier_mode_reserved <= 1'b0;
        end else begin
            amplifier_enable        <= cfg.amp_on;
            amplifier_mode_reserved <= cfg.amp_rsvd;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            amplifier_gain_code   <= amg_code_of(AMG_RST_GAIN);
            amplifier_gain_factor <= 8'h01;
        end else begin
            amplifier_gain_code   <= amg_code_of(amplifier_gain_setting_r);
            amplifier_gain_factor <= cfg.gain_factor;
        end
    end

    chk_reset_values: assert property (@(posedge ref_clk)
        $rose(rst_n) |-> input_channel_select_r == 8'h01)
        else $error("input select not at reset value");
    chk_gain_reset: assert property (@(posedge ref_clk)
        $rose(rst_n) |-> amplifier_gain_setting_r == 8'h00)
        else $error("gain register not at reset value");
    chk_pos_follow: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_in ##2 1 |-> positive_input_select == $past(avs_writedata[7:4], 2))
        else $error("positive select does not follow write");
    chk_amp_enable: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ##1 amplifier_enable == ($past(amplifier_gain_setting_r[4:3]) == 2'h1))
        else $error("amplifier enable decode wrong");
    chk_gain_factor: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ##1 $past(amplifier_gain_setting_r[4:3]) == 2'h1 |->
        amplifier_gain_factor == (8'h01 << $past(amplifier_gain_setting_r[2:0])))
        else $error("gain factor not a power of two of the code");
    chk_bypass_unity: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ##1 $past(amplifier_gain_setting_r[4:3]) != 2'h1 |-> amplifier_gain_factor == 8'h01)
        else $error("bypass does not give unity");
    chk_write_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_gn |=> amplifier_gain_setting_r == $past(avs_writedata[7:0]))
        else $error("gain register lost written value");
    chk_read_data: assert property (@(posedge ref_clk) disable iff (!rst_n)
        avs_read & ~ack_r & hit_in |=> avs_readdata == {24'h0, $past(input_channel_select_r)})
        else $error("read data wrong");

    // bus handshake: exactly one wait cycle per request
    chk_wait_single: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (avs_read | avs_write) & avs_waitrequest
        |=> !avs_waitrequest)
        else $error("request not answered after one wait cycle");

    chk_wait_release: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !avs_waitrequest
        |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");

    chk_idle_wait: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !(avs_read | avs_write)
        |=> avs_waitrequest)
        else $error("waitrequest low without a request");

    chk_reset_wait: assert property (@(posedge ref_clk)
        $rose(rst_n)
        |-> avs_waitrequest)
        else $error("waitrequest low straight after reset");

    // register storage
    chk_insel_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_in
        |=> input_channel_select_r == $past(avs_writedata[7:0]))
        else $error("input select lost written value");

    chk_insel_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !wr_in
        |=> $stable(input_channel_select_r))
        else $error("input select changed without a write");

    chk_gain_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !wr_gn
        |=> $stable(amplifier_gain_setting_r))
        else $error("gain register changed without a write");

    chk_byte_guard: assert property (@(posedge ref_clk) disable iff (!rst_n)
        avs_write & ~avs_waitrequest & ~avs_byteenable[0]
        |=> $stable(input_channel_select_r) && $stable(amplifier_gain_setting_r))
        else $error("write stored with low byte disabled");

    chk_insel_only: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_in
        |=> $stable(amplifier_gain_setting_r))
        else $error("input select write touched gain register");

    chk_gain_only: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wr_gn
        |=> $stable(input_channel_select_r))
        else $error("gain write touched input select");

    chk_unmapped_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
        avs_write & ack_r & ~hit_in & ~hit_gn
        |=> $stable(input_channel_select_r) && $stable(amplifier_gain_setting_r))
        else $error("unmapped write changed a register");

    chk_read_no_state: assert property (@(posedge ref_clk) disable iff (!rst_n)
        avs_read
        |=> $stable(input_channel_select_r) && $stable(amplifier_gain_setting_r))
        else $error("read changed a register");

    // read path
    chk_unmapped_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
        avs_read & ~ack_r & ~hit_in & ~hit_gn
        |=> avs_readdata == AMG_UNMAPPED)
        else $error("unmapped read not zero");

    chk_gain_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
        avs_read & ~ack_r & hit_gn
        |=> avs_readdata == {24'h0, $past(amplifier_gain_setting_r)})
        else $error("gain read data wrong");

    chk_readdata_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !(avs_read & ~ack_r)
        |=> $stable(avs_readdata))
        else $error("read data changed without a read");

    chk_answer_data: assert property (@(posedge ref_clk) disable iff (!rst_n)
        avs_read & ~avs_waitrequest
        |-> avs_readdata == $past(rdata_nxt))
        else $error("read data not ready at the answer");

    chk_readdata_upper: assert property (@(posedge ref_clk) disable iff (!rst_n)
        1'b1
        |-> avs_readdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");

    // decoded configuration outputs
    chk_pos_track: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ##1 1'b1
        |-> positive_input_select == amg_hi_nib($past(input_channel_select_r)))
        else $error("positive select does not track register");

    chk_neg_track: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ##1 1'b1
        |-> negative_input_select == amg_lo_nib($past(input_channel_select_r)))
        else $error("negative select does not track register");

    chk_code_track: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ##1 1'b1
        |-> amplifier_gain_code == amg_code_of($past(amplifier_gain_setting_r)))
        else $error("gain code does not track register");

    chk_rsvd_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ##1 1'b1
        |-> amplifier_mode_reserved == $past(amplifier_gain_setting_r[AMG_EN_MSB]))
        else $error("reserved mode flag wrong");

    chk_factor_onehot: assert property (@(posedge ref_clk) disable iff (!rst_n)
        1'b1
        |-> $onehot(amplifier_gain_factor))
        else $error("gain factor not a power of two");

    chk_enable_excl: assert property (@(posedge ref_clk) disable iff (!rst_n)
        amplifier_enable
        |-> !amplifier_mode_reserved)
        else $error("amplifier on with a reserved code");

    chk_bypass_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ##1 amg_mode_of($past(amplifier_gain_setting_r)) == AMG_EN_BYPASS
        |-> !amplifier_enable && !amplifier_mode_reserved)
        else $error("bypass code does not power the amplifier down");

    chk_code_factor: assert property (@(posedge ref_clk) disable iff (!rst_n)
        amplifier_enable
        |-> amplifier_gain_factor == (8'h01 << amplifier_gain_code))
        else $error("gain factor disagrees with gain code");

    chk_factor_unity: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !amplifier_enable
        |-> amplifier_gain_factor == 8'h01)
        else $error("gain factor not unity with amplifier off");

    // outputs right after reset release
    chk_reset_selects: assert property (@(posedge ref_clk)
        $rose(rst_n)
        |-> positive_input_select == 4'h0 && negative_input_select == 4'h1)
        else $error("input selects not at reset value");

    chk_reset_amp: assert property (@(posedge ref_clk)
        $rose(rst_n)
        |-> !amplifier_enable && amplifier_gain_code == 3'h0 && amplifier_gain_factor == 8'h01)
        else $error("amplifier outputs not at reset value");

    chk_reset_rdata: assert property (@(posedge ref_clk)
        $rose(rst_n)
        |-> avs_readdata == 32'h0)
        else $error("read data not cleared by reset");
endmodule : amg_regs

// *** amg_regs_tb.sv ***
// self-checking testbench for the input mux and amplifier gain register bank
`timescale 1ns/1ps
module amg_regs_tb;
    import amg_pkg::*;
    logic        ref_clk, rst_n, avs_read, avs_write, avs_waitrequest;
    logic        amplifier_enable, amplifier_mode_reserved;
    logic [3:0]  avs_address, avs_byteenable, positive_input_select, negative_input_select;
    logic [31:0] avs_writedata, avs_readdata;
    logic [2:0]  amplifier_gain_code;
    logic [7:0]  amplifier_gain_factor, v, s;
    logic [31:0] exp_q[$];
    int          mismatches, cmp_count, cycles, seed;

    amg_regs DUT (.ref_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .positive_input_select,
        .negative_input_select, .amplifier_enable, .amplifier_mode_reserved,
        .amplifier_gain_code, .amplifier_gain_factor);

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    task automatic stop_test();
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : stop_test

    task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask : cmp

    // one avalon cycle: hold everything until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        @(posedge ref_clk);
        avs_address <= a; avs_writedata <= d; avs_byteenable <= be;
        avs_read <= ~w; avs_write <= w;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
        avs_read <= 1'b0; avs_write <= 1'b0;
    endtask : bus

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        exp_q.push_back({24'h0, e});
        bus(1'b0, a, 32'h0, 4'hf);
    endtask : rd

    task automatic chk_cfg(input logic [7:0] ins, input logic en, input logic rs,
                           input logic [2:0] gc, input logic [7:0] gf);
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        cmp("config", {11'h0, ins, en, rs, gc, gf}, {11'h0, positive_input_select,
            negative_input_select, amplifier_enable, amplifier_mode_reserved,
            amplifier_gain_code, amplifier_gain_factor});
    endtask : chk_cfg

    // read monitor: oldest note against the data seen at the answering edge
    always @(posedge ref_clk) begin
        if (rst_n === 1'b1 && avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0)
            cmp("readdata", exp_q.pop_front(), avs_readdata);
    end

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            stop_test();
        end
    end

    initial begin
        seed = 97746; cycles = 0; mismatches = 0; cmp_count = 0;
        rst_n = 1'b0; avs_read = 1'b0; avs_write = 1'b0; avs_address = 4'h0;
        avs_writedata = 32'h0; avs_byteenable = 4'hf;
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        chk_cfg(8'h01, 1'b0, 1'b0, 3'h0, 8'h01);
        rd(AMG_OFS_INSEL, 8'h01);
        rd(AMG_OFS_GAIN, 8'h00);
        repeat (4) begin
            s = $random(seed);
            bus(1'b1, AMG_OFS_INSEL, $random(seed) & 32'hffff_ff00 | s, 4'hf);
            chk_cfg(s, 1'b0, 1'b0, 3'h0, 8'h01);
            rd(AMG_OFS_INSEL, s);
        end
        for (int m = 0; m < 4; m++) begin
            for (int g = 0; g < 8; g++) begin
                v = {3'h0, m[1:0], (m == 0) ? 3'h0 : g[2:0]};
                bus(1'b1, AMG_OFS_GAIN, {24'h0, v}, 4'hf);
                chk_cfg(s, m == 1, m[1], v[2:0], (m == 1) ? 8'h01 << g : 8'h01);
            end
        end
        bus(1'b1, AMG_OFS_GAIN, 32'h0000_00e9, 4'hf);
        rd(AMG_OFS_GAIN, 8'he9);
        chk_cfg(s, 1'b1, 1'b0, 3'h1, 8'h02);
        bus(1'b1, AMG_OFS_GAIN, 32'h0000_0000, 4'he);
        rd(AMG_OFS_GAIN, 8'he9);
        bus(1'b1, 4'h5, 32'h0000_00ff, 4'hf);
        rd(4'h5, 8'h00);
        rd(AMG_OFS_INSEL, s);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        chk_cfg(8'h01, 1'b0, 1'b0, 3'h0, 8'h01);
        rd(AMG_OFS_INSEL, 8'h01);
        rd(AMG_OFS_GAIN, 8'h00);
        repeat (3) @(posedge ref_clk);
        stop_test();
    end
endmodule : amg_regs_tb
